// *** tag_ctrl.sv ***
/*
 Tag presence and tracking control with an AXI4-Lite register slave.
 Assumes field_detect comes from the reader front end, asynchronous,
 and that job_finish is a one-cycle pulse from the tag engine.
*/
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "tag_ctrl_defines.svh"

module tag_ctrl
   import tag_ctrl_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        field_detect,
   input  wire logic        job_finish,
   output logic             field_on,
   output logic             job_start,
   output logic [1:0]       job_op,
   output logic             irq
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   logic [1:0]  mode_ff;
   logic        det_s1_ff, det_s2_ff;
   logic [7:0]  hyst_cnt_ff;
   logic        present_ff;
   job_state_t  state_ff;
   logic [1:0]  op_ff;
   logic [7:0]  err_ff;
   logic        seen_leave_ff;
   logic        unclosed_ff;
   result_t     res_ff;
   logic [3:0]  irq_stat_ff, irq_en_ff;
   logic        aw_ff, w_ff;
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        field_ff, start_ff, irq_ff;

   // ---------------------------------------------
   // Bus decode
   // ---------------------------------------------
   wire do_write = aw_ff && w_ff && !s_axi_bvalid;
   wire wr_mode  = do_write && awaddr_ff == `ADDR_MODE && wstrb_ff[0];
   wire wr_cmd   = do_write && awaddr_ff == `ADDR_CMD && wstrb_ff[0];
   wire wr_clr   = do_write && awaddr_ff == `ADDR_IRQ_CLEAR;
   wire wr_en    = do_write && awaddr_ff == `ADDR_IRQ_ENABLE;
   wire wr_ok    = awaddr_ff == `ADDR_MODE || awaddr_ff == `ADDR_CMD ||
                   awaddr_ff == `ADDR_IRQ_CLEAR || awaddr_ff == `ADDR_IRQ_ENABLE;
   wire do_read  = s_axi_arvalid && s_axi_arready;
   wire rd_res   = do_read && s_axi_araddr == `ADDR_RESULT;
   wire [1:0] cmd_code = wdata_ff[1:0];
   wire is_next  = wr_cmd && cmd_code == CMD_NEXT;
   wire is_job   = wr_cmd && cmd_code != CMD_NEXT;
   wire tracking = mode_ff == MODE_TRACK;
   wire scanning = mode_ff != MODE_OFF;

   logic [31:0] rd_word;
   logic        rd_ok;
   always_comb
   begin
      rd_ok   = 1'b1;
      rd_word = 32'h0;
      if (s_axi_araddr == `ADDR_MODE)
         rd_word = {30'h0, mode_ff};
      else if (s_axi_araddr == `ADDR_STATUS)
         rd_word = {20'h0, err_ff, state_ff, field_ff, present_ff};
      else if (s_axi_araddr == `ADDR_RESULT)
         rd_word = {22'h0, res_ff.data_valid, res_ff.done, res_ff.err};
      else if (s_axi_araddr == `ADDR_IRQ_STATUS)
         rd_word = {28'h0, irq_stat_ff};
      else if (s_axi_araddr == `ADDR_IRQ_ENABLE)
         rd_word = {28'h0, irq_en_ff};
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         aw_ff <= 1'b0; w_ff <= 1'b0; awaddr_ff <= 8'h0; wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
      end
      else
      begin
         // Take each channel only on a real handshake
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ff <= 1'b1; awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ff <= 1'b1; wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_ff <= 1'b0; w_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   assign s_axi_awready = !aw_ff && !s_axi_bvalid;
   assign s_axi_wready  = !w_ff && !s_axi_bvalid;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h0;
      end
      else if (do_read)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   assign s_axi_arready = !s_axi_rvalid;

   // ---------------------------------------------
   // Presence detection
   // ---------------------------------------------
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         det_s1_ff <= 1'b0; det_s2_ff <= 1'b0;
      end
      else
      begin
         det_s1_ff <= field_detect; det_s2_ff <= det_s1_ff;
      end
   end

   wire det_live = det_s2_ff && field_ff;
   wire differs  = det_live != present_ff;
   wire [7:0] hyst_lim = present_ff ? `HYST_OFF_CYCLES : `HYST_ON_CYCLES;
   wire flip = differs && hyst_cnt_ff == hyst_lim - 8'h1;
   wire enter_ev = flip && !present_ff;
   wire leave_ev = flip && present_ff;

   // Flag set on entry, cleared on leave
   // Flag tracks the field in every job state
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         hyst_cnt_ff <= 8'h0; present_ff <= 1'b0;
      end
      else
      begin
         hyst_cnt_ff <= (differs && !flip) ? hyst_cnt_ff + 8'h1 : 8'h0;
         if (flip)
            present_ff <= !present_ff;
      end
   end

   // ---------------------------------------------
   // Mode and field control
   // ---------------------------------------------
   // Scanning default
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         mode_ff <= `MODE_RESET;
      else if (wr_mode && wdata_ff[1:0] != 2'b11)
         mode_ff <= wdata_ff[1:0];
   end

   // Field only during a job in mode 0
   wire nxt_field = scanning || state_ff == ST_PENDING || state_ff == ST_EXEC;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         field_ff <= 1'b0;
      else
         field_ff <= nxt_field;
   end

   // ---------------------------------------------
   // Job sequencing
   // ---------------------------------------------
   logic       next_ok;
   job_state_t nxt_state;
   logic [7:0] nxt_err;
   logic       go;
   always_comb
   begin
      nxt_state = state_ff;
      nxt_err   = err_ff;
      next_ok   = 1'b0;
      go        = 1'b0;
      if (rd_res && res_ff.done && res_ff.err == err_ff)
         nxt_err = `ERR_NONE;
      case (state_ff)
         ST_IDLE, ST_DONE:
         begin
            if (is_job)
               nxt_state = ST_PENDING;
            // Advance hands over to next tag
            if (is_next && tracking)
            begin
               next_ok   = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_PENDING:
         begin
            // Held until a tag is present; in tracking mode, until old tag left and new one entered
            if (present_ff && !(tracking && !seen_leave_ff))
            begin
               nxt_state = ST_EXEC;
               go        = 1'b1;
            end
         end
         ST_EXEC:
         begin
            if (leave_ev && tracking)
            begin
               nxt_state = ST_DONE;
               nxt_err   = `ERR_LEFT;
            end
            else if (job_finish)
               nxt_state = ST_DONE;
         end
         default: nxt_state = ST_IDLE;
      endcase
      // Advance refused without tracking, in any state
      if (is_next && !tracking)
         nxt_err = `ERR_NO_TRACK;
      if (tracking && leave_ev && state_ff != ST_EXEC &&
          (unclosed_ff || state_ff == ST_IDLE))
         nxt_err = `ERR_PASSAGE;
   end

   wire job_aborted = state_ff == ST_EXEC && leave_ev && tracking;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= ST_IDLE; err_ff <= `ERR_NONE; op_ff <= 2'h0; start_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         err_ff   <= nxt_err;
         start_ff <= go;
         if (is_job && (state_ff == ST_IDLE || state_ff == ST_DONE))
            op_ff <= cmd_code;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         seen_leave_ff <= 1'b1; unclosed_ff <= 1'b0;
      end
      else
      begin
         if (next_ok)
            seen_leave_ff <= !present_ff;
         else if (leave_ev)
            seen_leave_ff <= 1'b1;
         else if (go)
            seen_leave_ff <= 1'b0;
         if (go)
            unclosed_ff <= 1'b1;
         else if (next_ok || !tracking)
            unclosed_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         res_ff <= '0;
      else if (state_ff == ST_EXEC && nxt_state == ST_DONE)
         res_ff <= '{data_valid: !job_aborted, done: 1'b1, err: nxt_err};
      else if (is_next || (is_job && state_ff != ST_EXEC))
         res_ff <= '{data_valid: 1'b0, done: 1'b1, err: nxt_err};
      else if (rd_res)
         res_ff.done <= 1'b0;
   end

   // ---------------------------------------------
   // Interrupts
   // ---------------------------------------------
   wire [3:0] irq_set = {leave_ev, enter_ev, nxt_err != err_ff && nxt_err != 8'h0,
                         state_ff == ST_EXEC && nxt_state == ST_DONE};
   wire [3:0] irq_clr = wr_clr ? wdata_ff[3:0] : 4'h0;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_stat_ff <= 4'h0; irq_en_ff <= 4'h0; irq_ff <= 1'b0;
      end
      else
      begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
         if (wr_en)
            irq_en_ff <= wdata_ff[3:0];
         irq_ff <= |(irq_stat_ff & irq_en_ff);
      end
   end

   assign field_on  = field_ff;
   assign job_start = start_ff;
   assign job_op    = op_ff;
   assign irq       = irq_ff;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   reset_mode_a: assert property (@(posedge clock) $rose(rstn) |-> mode_ff == 2'h1)
      else $error("mode not scanning after reset");
   scan_field_a: assert property (@(posedge clock) disable iff (!rstn)
      mode_ff != 2'h0 |=> field_ff)
      else $error("field off while scanning");
   hyst_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      $changed(present_ff) |=> $stable(present_ff))
      else $error("presence toggled twice");
   next_rej_a: assert property (@(posedge clock) disable iff (!rstn)
      is_next && mode_ff != 2'h2 |=> err_ff == 8'h10)
      else $error("advance not rejected");
   leave_abort_a: assert property (@(posedge clock) disable iff (!rstn)
      job_aborted |=> state_ff == ST_DONE && err_ff == 8'h01 && !res_ff.data_valid)
      else $error("leave did not abort");
   off_idle_a: assert property (@(posedge clock) disable iff (!rstn)
      mode_ff == 2'h0 && state_ff == ST_IDLE && !is_job |=> !field_ff)
      else $error("field on while idle in mode 0");
   pend_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      state_ff == ST_PENDING && !present_ff |=> state_ff == ST_PENDING)
      else $error("job left pending with no tag");
   passage_err_a: assert property (@(posedge clock) disable iff (!rstn)
      tracking && leave_ev && state_ff == ST_IDLE |=> err_ff == 8'h02)
      else $error("passage not flagged");

endmodule // tag_ctrl
`default_nettype wire

// *** tag_ctrl_defines.svh ***
/*
 Constants for the tag presence and tracking control block.
 Assumes inclusion by the control module and the bench only.
*/
`ifndef TAG_CTRL_DEFINES_SVH
`define TAG_CTRL_DEFINES_SVH

`define ADDR_MODE        8'h00
`define ADDR_CMD         8'h04
`define ADDR_STATUS      8'h08
`define ADDR_RESULT      8'h0c
`define ADDR_IRQ_STATUS  8'h10
`define ADDR_IRQ_CLEAR   8'h14
`define ADDR_IRQ_ENABLE  8'h18

`define MODE_RESET       2'h1
`define ERR_NONE         8'h00
`define ERR_LEFT         8'h01
`define ERR_PASSAGE      8'h02
`define ERR_NO_TRACK     8'h10

`define HYST_ON_CYCLES   8'h10
`define HYST_OFF_CYCLES  8'h10

`define IRQ_DONE_BIT     0
`define IRQ_ERR_BIT      1
`define IRQ_ENTER_BIT    2
`define IRQ_LEAVE_BIT    3

`endif

// *** tag_ctrl_pkg.sv ***
/*
 Types for the tag presence and tracking control block.
 Assumes the defines header is available on the include path.
*/
package tag_ctrl_pkg;

   typedef enum logic [1:0]
   {
      MODE_OFF   = 2'b00,
      MODE_SCAN  = 2'b01,
      MODE_TRACK = 2'b10
   } track_mode_t;

   typedef enum logic [1:0]
   {
      CMD_READ  = 2'b00,
      CMD_WRITE = 2'b01,
      CMD_INIT  = 2'b10,
      CMD_NEXT  = 2'b11
   } cmd_op_t;

   typedef enum logic [1:0]
   {
      ST_IDLE    = 2'b00,
      ST_PENDING = 2'b01,
      ST_EXEC    = 2'b10,
      ST_DONE    = 2'b11
   } job_state_t;

   typedef struct packed
   {
      logic       data_valid;
      logic       done;
      logic [7:0] err;
   } result_t;

endpackage

// *** tag_field_model.sv ***
/*
 Reader front end and tag engine model for the tag control bench.
 Assumes one clock and an active-low async reset from the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module tag_field_model
(
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       field_on,
   input  wire logic       job_start,
   input  wire logic       tag_here,
   input  wire logic [3:0] fin_dly,
   output logic            field_detect,
   output logic            job_finish
);
   logic [5:0] cnt_ff;
   logic       busy_ff;
   // ----
   // Sensing
   // ----
   // one field here
   assign field_detect = tag_here && field_on;
   // ----
   // Engine
   // ----
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         busy_ff    <= 1'b0;
         cnt_ff     <= 6'h00;
         job_finish <= 1'b0;
      end
      else
      begin
         job_finish <= 1'b0;
         if (job_start)
         begin
            busy_ff <= 1'b1;
            cnt_ff  <= {fin_dly, 2'b11};
         end
         else if (busy_ff && cnt_ff == 6'h00)
         begin
            busy_ff    <= 1'b0;
            job_finish <= 1'b1;
         end
         else if (busy_ff)
            cnt_ff <= cnt_ff - 6'h01;
      end
   end
endmodule // tag_field_model

`default_nettype wire

// *** tb_top.sv ***
/*
 Self-checking bench for the tag presence and tracking control block.
 Assumes the package, the defines header and the tag field model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tag_ctrl_defines.svh"

module tb_top
   import tag_ctrl_pkg::*;
();
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, seed = 32'h4972;
   logic [3:0]  s_axi_wstrb = 4'hf, fin_dly = 4'h3;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, tag_here = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, field_detect, job_finish, field_on, job_start, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, job_op, r;
   logic [1:0]  op_q[$];
   int          errors = 0;
   int          check_count = 0;

   always #10 clock = ~clock;

   tag_ctrl u_dut (.clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .field_detect(field_detect), .job_finish(job_finish),
      .field_on(field_on), .job_start(job_start), .job_op(job_op), .irq(irq));

   tag_field_model u_tag (.clock(clock), .rstn(rstn), .field_on(field_on),
      .job_start(job_start), .tag_here(tag_here), .fin_dly(fin_dly),
      .field_detect(field_detect), .job_finish(job_finish));

   // ----
   // Helpers
   // ----
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic pin(ref logic v, input logic e);
      @(negedge clock);
      chk({31'h0, v}, {31'h0, e});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      logic ah, wh, bh;
      n = 0;
      bh = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!bh && n < 100)
      begin
         @(negedge clock);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         r = s_axi_bresp;
         n++;
         @(posedge clock);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         if (bh) s_axi_bready <= 1'b0;
      end
      if (!bh) errors++;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      logic ah, rh;
      n = 0;
      rh = 0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!rh && n < 100)
      begin
         @(negedge clock);
         ah = s_axi_arvalid && s_axi_arready;
         rh = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         n++;
         @(posedge clock);
         if (ah) s_axi_arvalid <= 1'b0;
         if (rh) s_axi_rready <= 1'b0;
      end
      if (!rh) errors++;
   endtask

   // Job request, long engine time or a random one
   task automatic cmd(input cmd_op_t op, input logic slow);
      seed = lfsr(seed);
      @(posedge clock);
      fin_dly <= slow ? 4'hf : seed[3:0];
      if (op != CMD_NEXT) op_q.push_back(op);
      wr(`ADDR_CMD, {30'h0, op});
   endtask

   task automatic wait_start();
      for (int n = 0; n < 200; n++)
      begin
         @(negedge clock);
         if (job_start)
         begin
            chk({30'h0, job_op}, {30'h0, op_q.pop_front()});
            return;
         end
      end
      errors++;
   endtask

   task automatic tg(input logic v, input int n);
      @(posedge clock);
      tag_here <= v;
      repeat (n) @(posedge clock);
   endtask

   task print_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ----
   // Watchdog
   // ----
   initial
   begin
      repeat (20000) @(posedge clock);
      errors++;
      print_verdict();
   end

   // ----
   // Scenarios
   // ----
   initial
   begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      rd(`ADDR_MODE);
      chk(d, 32'h1);
      pin(field_on, 1'b1);
      tg(1, 8);
      tg(0, 30);
      rd(`ADDR_STATUS);
      chk(d & 32'h1, 32'h0);
      tg(1, 40);
      rd(`ADDR_STATUS);
      chk(d & 32'h3, 32'h3);
      cmd(CMD_NEXT, 0);
      rd(`ADDR_RESULT);
      chk(d & 32'hff, 32'h10);
      cmd(CMD_READ, 0);
      wait_start();
      tg(0, 30);
      rd(`ADDR_STATUS);
      chk(d & 32'h1, 32'h0);
      repeat (80) @(posedge clock);
      rd(`ADDR_RESULT);
      chk(d & 32'hff, 32'h0);
      wr(`ADDR_MODE, 32'h0);
      tg(1, 5);
      pin(field_on, 1'b0);
      cmd(CMD_INIT, 0);
      wait_start();
      pin(field_on, 1'b1);
      repeat (90) @(posedge clock);
      pin(field_on, 1'b0);
      wr(`ADDR_MODE, 32'h2);
      pin(field_on, 1'b1);
      repeat (40) @(posedge clock);
      rd(`ADDR_STATUS);
      chk(d & 32'h3, 32'h3);
      cmd(CMD_WRITE, 1);
      wait_start();
      tg(0, 40);
      rd(`ADDR_RESULT);
      chk(d & 32'h2ff, 32'h001);
      repeat (60) @(posedge clock);
      cmd(CMD_NEXT, 0);
      chk({30'h0, r}, 32'h0);
      cmd(CMD_READ, 0);
      tg(1, 0);
      wait_start();
      repeat (80) @(posedge clock);
      rd(`ADDR_RESULT);
      chk(d & 32'h3ff, 32'h300);
      cmd(CMD_NEXT, 0);
      tg(0, 40);
      tg(1, 40);
      tg(0, 40);
      rd(`ADDR_STATUS);
      chk((d >> 4) & 32'hff, 32'h02);
      cmd(CMD_INIT, 0);
      rd(`ADDR_RESULT);
      chk(d & 32'hff, 32'h02);
      rd(`ADDR_STATUS);
      chk((d >> 4) & 32'hff, 32'h00);
      wr(`ADDR_IRQ_ENABLE, 32'hf);
      pin(irq, 1'b1);
      wr(`ADDR_IRQ_CLEAR, 32'hf);
      repeat (2) @(posedge clock);
      pin(irq, 1'b0);
      wr(`ADDR_IRQ_ENABLE, 32'h0);
      tg(1, 40);
      pin(irq, 1'b0);
      rd(`ADDR_IRQ_STATUS);
      chk(d & 32'h4, 32'h4);
      wr(`ADDR_IRQ_ENABLE, 32'h4);
      repeat (2) @(posedge clock);
      pin(irq, 1'b1);
      rd(8'h40);
      chk({30'h0, r}, 32'h2);
      wr(`ADDR_STATUS, 32'h0);
      chk({30'h0, r}, 32'h2);
      wr(`ADDR_MODE, 32'h3);
      rd(`ADDR_MODE);
      chk(d, 32'h2);
      print_verdict();
   end
endmodule // tb_top

`default_nettype wire
